// file: bench/ssc_readout_ctrl_tb.sv
`timescale 1ns/10ps
module ssc_readout_ctrl_tb;
  import ssc_pkg::*;
  localparam int ROWS = 8;
  localparam int COLS = 16;
  localparam int BLANK = 2;
  logic ref_clk = 1'b0;
  logic sys_rst = 1'b1;
  ssc_reg_wr_t regWr = '0;
  logic [7:0] regRdAddr = 8'h00;
  logic [7:0] regRdData;
  logic trigPin = 1'b0;
  logic singleFrameSel = 1'b0;
  logic [11:0] integLines = 12'h002;
  logic [SSC_IDX_W-1:0] rowAddr;
  logic [SSC_IDX_W-1:0] colAddr;
  logic pixelValid;
  logic rowSumOut;
  logic strobeOut;
  logic frameActive;
  logic prevActive = 1'b0;
  int errors = 0;
  int comparisons = 0;
  int starts = 0;
  int strobeCyc = 0;
  int fires;

  ssc_readout_ctrl #(.WIN_ROWS(ROWS), .WIN_COLS(COLS), .LINE_BLANK(BLANK)) uut (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .regWr(regWr), .regRdAddr(regRdAddr),
    .regRdData(regRdData), .trigPin(trigPin), .singleFrameSel(singleFrameSel),
    .integLines(integLines), .rowAddr(rowAddr), .colAddr(colAddr),
    .pixelValid(pixelValid), .rowSumOut(rowSumOut), .strobeOut(strobeOut),
    .frameActive(frameActive)
  );
  ssc_shutter_model flash_drv (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .strobeOut(strobeOut), .fires(fires)
  );

  // 200 MHz clock
  always #2.5 ref_clk = ~ref_clk;

  // Frame starts and strobe high cycles
  always @(posedge ref_clk) begin
    prevActive <= frameActive;
    if (frameActive && !prevActive) starts <= starts + 1;
    if (strobeOut) strobeCyc <= strobeCyc + 1;
  end

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : tally_and_finish

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    regWr <= '{en: 1'b1, addr: a, data: d};
    @(posedge ref_clk);
    regWr.en <= 1'b0;
    @(posedge ref_clk);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    regRdAddr <= a;
    repeat (2) @(posedge ref_clk);
    #1 check("register", {8'h00, regRdData}, {8'h00, exp});
    @(posedge ref_clk);
  endtask : rd

  // Waits for the next whole frame and gathers its pixels
  task automatic frame(input int flipAt, output int cnt, output int sum, output int cyc,
                       output logic seen);
    int w;
    cnt = 0;
    sum = 0;
    cyc = 0;
    seen = 1'b0;
    w = 0;
    #1;
    while (frameActive !== 1'b0 && w < 3000) begin
      @(posedge ref_clk) #1;
      w++;
    end
    while (frameActive !== 1'b1 && w < 3000) begin
      @(posedge ref_clk) #1;
      w++;
    end
    while (frameActive === 1'b1 && cyc < 3000) begin
      if (pixelValid === 1'b1) begin
        cnt++;
        sum += int'(rowAddr) + int'(colAddr);
        seen |= rowSumOut;
      end
      cyc++;
      @(posedge ref_clk);
      if (cyc == flipAt) singleFrameSel <= 1'b1;
      #1;
    end
    @(posedge ref_clk);
  endtask : frame

  function automatic logic pick(input int i, input logic [1:0] f, input logic k);
    return ((i / (k ? 2 : 1)) % (1 << f)) == 0;
  endfunction : pick

  // Main sequence
  initial begin
    int cnt, sum, cyc, nr, nc, sr, sc, s0;
    logic seen;
    static logic [7:0] cfg [5] = '{8'h00, 8'h07, 8'h1d, 8'h0a, 8'h17};
    static logic [7:0] tv [6] = '{8'h01, 8'h00, 8'h04, 8'h04, 8'h02, 8'h06};
    static logic tp [6] = '{1'b0, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0};
    static int te [6] = '{1, 0, 2, 0, 2, 2};
    static logic [7:0] sv [3] = '{8'h19, 8'h09, 8'h11};
    static int se [3] = '{72, 18, 0};
    repeat (8) @(posedge ref_clk);
    sys_rst <= 1'b0;
    @(posedge ref_clk);
    rd(SSC_ADDR_SUBSAMPLE, 8'h10);
    rd(SSC_ADDR_TRIGSTROBE, 8'h02);
    rd(8'h43, 8'h00);
    wr(SSC_ADDR_SUBSAMPLE, 8'hbf);
    rd(SSC_ADDR_SUBSAMPLE, 8'h3f);
    wr(SSC_ADDR_TRIGSTROBE, 8'hdf);
    rd(SSC_ADDR_TRIGSTROBE, 8'h1e);
    wr(SSC_ADDR_TRIGSTROBE, 8'h00);
    $display("test registers done");
    for (int i = 0; i < 5; i++) begin
      wr(SSC_ADDR_SUBSAMPLE, cfg[i]);
      nr = 0;
      nc = 0;
      sr = 0;
      sc = 0;
      for (int r = 0; r < ROWS; r++) begin
        if (pick(r, cfg[i][3:2], cfg[i][4])) begin
          nr++;
          sr += r;
        end
      end
      for (int c = 0; c < COLS; c++) begin
        if (pick(c, cfg[i][1:0], cfg[i][4])) begin
          nc++;
          sc += c;
        end
      end
      repeat (2) frame(0, cnt, sum, cyc, seen);
      check("pixels", 16'(cnt), 16'(nr * nc));
      check("addr sum", 16'(sum), 16'(nc * sr + nr * sc));
      check("row sum", {15'h0, seen}, 16'h0000);
      check("cycles", {15'h0, cyc <= nr * (nc + BLANK + 1) + 2}, 16'h0001);
      $display("test subsample %h done", cfg[i]);
    end
    wr(SSC_ADDR_SUBSAMPLE, 8'h30);
    repeat (2) frame(0, cnt, sum, cyc, seen);
    check("row sum", {15'h0, seen}, 16'h0001);
    wr(SSC_ADDR_SUBSAMPLE, 8'h10);
    frame(0, cnt, sum, cyc, seen);
    frame(5, cnt, sum, cyc, seen);
    check("pixels", 16'(cnt), 16'(ROWS * COLS));
    s0 = starts;
    repeat (400) @(posedge ref_clk);
    check("starts", 16'(starts - s0), 16'h0000);
    $display("test mode switch done");
    for (int i = 0; i < 6; i++) begin
      trigPin <= tp[i];
      wr(SSC_ADDR_TRIGSTROBE, tv[i]);
      s0 = starts;
      repeat (600) @(posedge ref_clk);
      s0 = (starts - s0 > 2) ? 2 : starts - s0;
      check("starts", 16'(s0), 16'(te[i]));
      trigPin <= 1'b0;
      wr(SSC_ADDR_TRIGSTROBE, 8'h00);
      repeat (400) @(posedge ref_clk);
    end
    $display("test trigger done");
    integLines <= 12'h00c;
    for (int i = 0; i < 3; i++) begin
      s0 = strobeCyc;
      wr(SSC_ADDR_TRIGSTROBE, sv[i]);
      repeat (800) @(posedge ref_clk);
      check("strobe", 16'(strobeCyc - s0), 16'(se[i]));
    end
    singleFrameSel <= 1'b0;
    s0 = strobeCyc;
    wr(SSC_ADDR_TRIGSTROBE, 8'h0a);
    repeat (600) @(posedge ref_clk);
    check("strobe", 16'(strobeCyc - s0), 16'h0000);
    check("flashes", 16'(fires), 16'h0002);
    $display("test strobe done");
    tally_and_finish();
  end

  // Watchdog
  initial begin
    #200000;
    check("watchdog", 16'h0000, 16'h0001);
    tally_and_finish();
  end
endmodule : ssc_readout_ctrl_tb

// file: bench/ssc_shutter_model.sv
`timescale 1ns/10ps
// Flash driver on the strobe output; fires and quenches inside the strobe window
module ssc_shutter_model (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic strobeOut,
  output int fires
);
  logic lastStrobe;
  logic flash;
  // One-cycle flash after strobe rise, counted only if strobe still high
  always @(posedge ref_clk) begin
    if (sys_rst) begin
      lastStrobe <= 1'b0;
      flash <= 1'b0;
      fires <= 0;
    end else begin
      lastStrobe <= strobeOut;
      flash <= strobeOut && !lastStrobe;
      if (flash && strobeOut) fires <= fires + 1;
    end
  end
endmodule : ssc_shutter_model

// file: design/ssc_frame_go.sv
`timescale 1ns/10ps
// Internal frame trigger source: always-on, pin follower or one-cycle soft pulse
module ssc_frame_go
  import ssc_pkg::*;
(
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire ssc_go_ctrl_t goCtrl,
  input wire logic trigPin,
  output logic frameGo
);

  // Trigger selection; the soft pulse is a one-cycle write strobe
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      frameGo <= 1'b0;
    end else if (goCtrl.alwaysOn) begin
      frameGo <= 1'b1;
    end else if (goCtrl.softPulse) begin
      frameGo <= 1'b1;
    end else if (goCtrl.extEn) begin
      frameGo <= trigPin;
    end else begin
      frameGo <= 1'b0;
    end
  end

  property p_alwaysHigh;
    @(posedge ref_clk) disable iff (sys_rst) goCtrl.alwaysOn |=> frameGo;
  endproperty
  a_alwaysHigh: assert property (p_alwaysHigh) else $error("always-on did not hold go");

  property p_pinFollow;
    @(posedge ref_clk) disable iff (sys_rst)
      goCtrl.extEn && !goCtrl.alwaysOn && !goCtrl.softPulse |=> frameGo == $past(trigPin);
  endproperty
  a_pinFollow: assert property (p_pinFollow) else $error("go did not follow pin");

  property p_softOnce;
    @(posedge ref_clk) disable iff (sys_rst)
      goCtrl.softPulse ##1 (!goCtrl.softPulse && !goCtrl.alwaysOn && !goCtrl.extEn)
      |-> ##1 !frameGo;
  endproperty
  a_softOnce: assert property (p_softOnce) else $error("soft pulse longer than one cycle");

  property p_quiet;
    @(posedge ref_clk) disable iff (sys_rst)
      !goCtrl.softPulse && !goCtrl.alwaysOn && !goCtrl.extEn |=> !frameGo;
  endproperty
  a_quiet: assert property (p_quiet) else $error("go high with no source");

endmodule : ssc_frame_go

// file: design/ssc_pkg.sv
package ssc_pkg;

  // Register map of the serial-bus register file
  localparam logic [7:0] SSC_ADDR_SUBSAMPLE = 8'h41;
  localparam logic [7:0] SSC_ADDR_TRIGSTROBE = 8'h42;
  localparam logic [7:0] SSC_RST_SUBSAMPLE = 8'h10;
  localparam logic [7:0] SSC_RST_TRIGSTROBE = 8'h02;
  // Storage masks: bit 7 of both and bits 6 of the trigger register are unused
  localparam logic [7:0] SSC_MASK_SUBSAMPLE = 8'h7f;
  localparam logic [7:0] SSC_MASK_TRIGSTROBE = 8'h3f;

  // Sub-sample control fields
  localparam int SSC_COL_SKIP_LSB = 0;
  localparam int SSC_ROW_SKIP_LSB = 2;
  localparam int SSC_COLOR_KERNEL_BIT = 4;
  localparam int SSC_ROW_SUM_BIT = 5;

  // Trigger and strobe control fields
  localparam int SSC_SOFT_PULSE_BIT = 0;
  localparam int SSC_ALWAYS_ON_BIT = 1;
  localparam int SSC_EXT_GO_BIT = 2;
  localparam int SSC_STROBE_EN_BIT = 3;
  localparam int SSC_STROBE_WIDTH_BIT = 4;

  // Index widths of the readout counters
  localparam int SSC_IDX_W = 11;
  localparam int SSC_LINE_W = 16;
  localparam logic [1:0] SSC_SKIP_FULL = 2'h0;

  typedef struct packed {
    logic en;
    logic [7:0] addr;
    logic [7:0] data;
  } ssc_reg_wr_t;

  typedef struct packed {
    logic softPulse;
    logic alwaysOn;
    logic extEn;
  } ssc_go_ctrl_t;

  typedef enum logic [1:0] {
    SSC_IDLE,
    SSC_INTEG,
    SSC_READ
  } ssc_state_t;

  // Next selected row or column index: reads one kernel, then jumps the skipped ones
  function automatic logic [SSC_IDX_W-1:0] ssc_next_idx(input logic [SSC_IDX_W-1:0] idx,
                                                        input logic [1:0] field,
                                                        input logic colorSel);
    logic [SSC_IDX_W-1:0] period;
    period = colorSel ? (SSC_IDX_W'(2) << field) : (SSC_IDX_W'(1) << field);
    if (field == SSC_SKIP_FULL) begin
      ssc_next_idx = idx + SSC_IDX_W'(1);
    end else if (colorSel && !idx[0]) begin
      ssc_next_idx = idx + SSC_IDX_W'(1);
    end else if (colorSel) begin
      ssc_next_idx = idx - SSC_IDX_W'(1) + period;
    end else begin
      ssc_next_idx = idx + period;
    end
  endfunction : ssc_next_idx

endpackage : ssc_pkg

// file: design/ssc_readout_ctrl.sv
`timescale 1ns/10ps
// Operation
// - Unselected pixels cost no readout cycles
// - Kernel bit clear: skip single rows, columns
// - Kernel bit set: skip rows, columns in pairs
// - Row field: full, 1/2, 1/4, 1/8
// - Column field selects pattern independently of rows
// - Binning bit sums even and odd rows
// - Strobe width: rest of integration once all rows integrate, or one line
// - Strobe only when enabled, single-frame mode
// - External enable makes trigger follow pin
// - Always-on bit holds trigger high
// - Soft bit gives one-cycle trigger pulse
// - Trigger stays low until soft bit rewritten
// - Single-frame: frames wait for trigger high
// - Single-frame select takes effect at frame end
module ssc_readout_ctrl
  import ssc_pkg::*;
#(
  parameter int WIN_ROWS = 1024,
  parameter int WIN_COLS = 1280,
  parameter int LINE_BLANK = 16
) (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire ssc_reg_wr_t regWr,
  input wire logic [7:0] regRdAddr,
  output logic [7:0] regRdData,
  input wire logic trigPin,
  input wire logic singleFrameSel,
  input wire logic [11:0] integLines,
  output logic [SSC_IDX_W-1:0] rowAddr,
  output logic [SSC_IDX_W-1:0] colAddr,
  output logic pixelValid,
  output logic rowSumOut,
  output logic strobeOut,
  output logic frameActive
);

  localparam logic [SSC_IDX_W-1:0] LAST_ROW = SSC_IDX_W'(WIN_ROWS - 1);
  localparam logic [SSC_IDX_W-1:0] LAST_COL = SSC_IDX_W'(WIN_COLS - 1);
  localparam logic [SSC_LINE_W-1:0] LINE_CYCLES = SSC_LINE_W'(WIN_COLS + LINE_BLANK);
  localparam logic [SSC_LINE_W-1:0] BLANK_LAST = SSC_LINE_W'(LINE_BLANK - 1);
  localparam logic [11:0] ALL_ROWS_LINES = 12'(WIN_ROWS);

  logic [7:0] subsample_reg;
  logic [7:0] trigstrobe_reg;
  logic softPulse_reg;
  logic single_reg;
  logic frameGo;
  logic softPending_reg;
  ssc_state_t state_reg;
  logic [SSC_LINE_W-1:0] lineCyc_reg;
  logic [11:0] lineCnt_reg;
  logic [SSC_LINE_W-1:0] blank_reg;
  logic inBlank_reg;
  logic [1:0] rowField_reg;
  logic [1:0] colField_reg;
  logic color_reg;
  logic rowSum_reg;
  logic [SSC_IDX_W-1:0] colIdx_reg;
  logic [SSC_IDX_W-1:0] rowIdx_reg;
  logic [SSC_IDX_W-1:0] colNext;
  logic [SSC_IDX_W-1:0] rowNext;
  logic lineEnd;
  logic frameEnd;
  logic goNow;
  ssc_go_ctrl_t goCtrl;

  // Register writes; factory bits are stored as written, unused bits read zero
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      subsample_reg <= SSC_RST_SUBSAMPLE;
      trigstrobe_reg <= SSC_RST_TRIGSTROBE;
    end else if (regWr.en && regWr.addr == SSC_ADDR_SUBSAMPLE) begin
      subsample_reg <= regWr.data & SSC_MASK_SUBSAMPLE;
    end else if (regWr.en && regWr.addr == SSC_ADDR_TRIGSTROBE) begin
      trigstrobe_reg <= regWr.data & SSC_MASK_TRIGSTROBE & ~(8'h01 << SSC_SOFT_PULSE_BIT);
    end
  end

  // Soft trigger: a one written to the bit yields a single-cycle strobe
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      softPulse_reg <= 1'b0;
    end else begin
      softPulse_reg <= regWr.en && regWr.addr == SSC_ADDR_TRIGSTROBE &&
                       regWr.data[SSC_SOFT_PULSE_BIT];
    end
  end

  // Register read port, one cycle latency
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      regRdData <= 8'h00;
    end else if (regRdAddr == SSC_ADDR_SUBSAMPLE) begin
      regRdData <= subsample_reg;
    end else if (regRdAddr == SSC_ADDR_TRIGSTROBE) begin
      regRdData <= trigstrobe_reg;
    end else begin
      regRdData <= 8'h00;
    end
  end

  assign goCtrl = '{softPulse: softPulse_reg,
                    alwaysOn: trigstrobe_reg[SSC_ALWAYS_ON_BIT],
                    extEn: trigstrobe_reg[SSC_EXT_GO_BIT]};

  ssc_frame_go u_frame_go (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .goCtrl(goCtrl),
    .trigPin(trigPin),
    .frameGo(frameGo)
  );

  // A soft pulse that lands mid-frame is held until the next frame start;
  // in continuous mode it is dropped so it cannot start a frame much later
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      softPending_reg <= 1'b0;
    end else if (softPulse_reg) begin
      softPending_reg <= 1'b1; // set wins over clear
    end else if (state_reg == SSC_IDLE || !single_reg) begin
      softPending_reg <= 1'b0;
    end
  end

  // Skipped pixels are jumped over, never clocked through
  assign colNext = ssc_next_idx(colIdx_reg, colField_reg, color_reg);
  assign rowNext = rowSum_reg ?
                   ssc_next_idx(rowIdx_reg >> 1, rowField_reg, color_reg) << 1 :
                   ssc_next_idx(rowIdx_reg, rowField_reg, color_reg);
  assign lineEnd = inBlank_reg && blank_reg == BLANK_LAST;
  assign frameEnd = lineEnd && (rowNext > LAST_ROW || rowNext < rowIdx_reg);
  assign goNow = frameGo || softPending_reg;

  // Capture mode changes only between frames
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      single_reg <= 1'b0;
    end else if ((state_reg == SSC_IDLE && !(single_reg && goNow)) || frameEnd) begin
      single_reg <= singleFrameSel;
    end
  end

  // Frame sequencer
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      state_reg <= SSC_IDLE;
    end else begin
      case (state_reg)
        SSC_IDLE: begin
          if (!single_reg) begin
            state_reg <= SSC_READ;
          end else if (goNow) begin
            state_reg <= SSC_INTEG;
          end
        end
        SSC_INTEG: begin
          if (lineCyc_reg == LINE_CYCLES - SSC_LINE_W'(1) && lineCnt_reg + 12'h001 >= integLines) begin
            state_reg <= SSC_READ;
          end
        end
        SSC_READ: begin
          if (frameEnd) begin
            state_reg <= SSC_IDLE;
          end
        end
        default: state_reg <= SSC_IDLE;
      endcase
    end
  end

  // Integration timing in whole line times
  always_ff @(posedge ref_clk) begin
    if (sys_rst || state_reg != SSC_INTEG) begin
      lineCyc_reg <= '0;
      lineCnt_reg <= '0;
    end else if (lineCyc_reg == LINE_CYCLES - SSC_LINE_W'(1)) begin
      lineCyc_reg <= '0;
      lineCnt_reg <= lineCnt_reg + 12'h001;
    end else begin
      lineCyc_reg <= lineCyc_reg + SSC_LINE_W'(1);
    end
  end

  // Sampling pattern is frozen for the whole frame
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      rowField_reg <= SSC_SKIP_FULL;
      colField_reg <= SSC_SKIP_FULL;
      color_reg <= 1'b1;
      rowSum_reg <= 1'b0;
    end else if (state_reg == SSC_IDLE) begin
      rowField_reg <= subsample_reg[SSC_ROW_SKIP_LSB +: 2];
      colField_reg <= subsample_reg[SSC_COL_SKIP_LSB +: 2];
      color_reg <= subsample_reg[SSC_COLOR_KERNEL_BIT];
      rowSum_reg <= subsample_reg[SSC_ROW_SUM_BIT];
    end
  end

  // Pixel walk: selected columns, then line blanking, then next selected row
  always_ff @(posedge ref_clk) begin
    if (sys_rst || state_reg != SSC_READ) begin
      colIdx_reg <= '0;
      rowIdx_reg <= '0;
      inBlank_reg <= 1'b0;
      blank_reg <= '0;
    end else if (inBlank_reg) begin
      blank_reg <= blank_reg + SSC_LINE_W'(1);
      if (lineEnd) begin
        inBlank_reg <= 1'b0;
        blank_reg <= '0;
        colIdx_reg <= '0;
        rowIdx_reg <= frameEnd ? '0 : rowNext;
      end
    end else if (colNext > LAST_COL || colNext < colIdx_reg) begin
      inBlank_reg <= 1'b1;
    end else begin
      colIdx_reg <= colNext;
    end
  end

  // Frame, pixel and binning outputs, one stage behind the walk so they align
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      rowSumOut <= 1'b0;
      frameActive <= 1'b0;
      pixelValid <= 1'b0;
      colAddr <= '0;
      rowAddr <= '0;
    end else begin
      rowSumOut <= rowSum_reg && state_reg == SSC_READ;
      frameActive <= state_reg == SSC_READ;
      pixelValid <= state_reg == SSC_READ && !inBlank_reg;
      colAddr <= colIdx_reg;
      rowAddr <= rowIdx_reg;
    end
  end

  // Strobe: all rows integrate once a full frame of line times has passed
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      strobeOut <= 1'b0;
    end else if (!trigstrobe_reg[SSC_STROBE_EN_BIT] || !single_reg ||
                 state_reg != SSC_INTEG) begin
      strobeOut <= 1'b0;
    end else if (trigstrobe_reg[SSC_STROBE_WIDTH_BIT]) begin
      strobeOut <= lineCnt_reg >= ALL_ROWS_LINES;
    end else begin
      strobeOut <= lineCnt_reg == ALL_ROWS_LINES;
    end
  end

  property p_resetValues;
    @(posedge ref_clk) $past(sys_rst) && !sys_rst |->
      subsample_reg == SSC_RST_SUBSAMPLE && trigstrobe_reg == SSC_RST_TRIGSTROBE;
  endproperty
  a_resetValues: assert property (p_resetValues) else $error("bad reset values");

  property p_strobeGated;
    @(posedge ref_clk) disable iff (sys_rst)
      strobeOut |-> $past(trigstrobe_reg[SSC_STROBE_EN_BIT]) && $past(single_reg);
  endproperty
  a_strobeGated: assert property (p_strobeGated) else $error("strobe while disabled");

  property p_strobeEndsAtRead;
    @(posedge ref_clk) disable iff (sys_rst)
      strobeOut && state_reg == SSC_READ |=> !strobeOut;
  endproperty
  a_strobeEndsAtRead: assert property (p_strobeEndsAtRead) else $error("strobe past readout");

  property p_contIgnoresGo;
    @(posedge ref_clk) disable iff (sys_rst) !single_reg |-> state_reg != SSC_INTEG;
  endproperty
  a_contIgnoresGo: assert property (p_contIgnoresGo) else $error("trigger used in continuous");

  property p_waitForGo;
    @(posedge ref_clk) disable iff (sys_rst)
      state_reg == SSC_IDLE && single_reg && !goNow |=> state_reg == SSC_IDLE;
  endproperty
  a_waitForGo: assert property (p_waitForGo) else $error("frame started without trigger");

  property p_monoEighth;
    @(posedge ref_clk) disable iff (sys_rst)
      pixelValid && !color_reg && colField_reg == 2'h3 |-> colAddr[2:0] == 3'h0;
  endproperty
  a_monoEighth: assert property (p_monoEighth) else $error("mono 1/8 column wrong");

  property p_colorHalf;
    @(posedge ref_clk) disable iff (sys_rst)
      pixelValid && color_reg && colField_reg == 2'h1 |-> colAddr[1] == 1'b0;
  endproperty
  a_colorHalf: assert property (p_colorHalf) else $error("colour 1/2 column wrong");

  property p_binEven;
    @(posedge ref_clk) disable iff (sys_rst) rowSumOut |-> !rowAddr[0];
  endproperty
  a_binEven: assert property (p_binEven) else $error("summed row pair misaligned");

endmodule : ssc_readout_ctrl
